// ===== design/kick_edge_detect.sv
`timescale 1ns/1ns
module kick_edge_detect
    import wdog_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic kick_in,
    output logic      kick_edge
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
    } kick_state_type;

    kick_state_type state_r;
    kick_state_type state_nxt;

    // Two-stage synchroniser; first stage feeds only the second
    always_comb begin
        state_nxt       = state_r;
        state_nxt.sync1 = kick_in;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.last  = state_r.sync2;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // Either edge restarts the window
    assign kick_edge = clk_en & (state_r.sync2 ^ state_r.last);

endmodule

// ===== design/watchdog_reset_supervisor.sv
`timescale 1ns/1ns
// Summary of operation
// - Silent kick input for window triggers reset
// - Any kick edge or reset restarts window
// - Kick pulses of 50 ns are recognised
// - Counter held at zero during reset
// - Counter starts right at reset release
// - Weak drive low 7/8, high last 1/8
// - Floating kick self-services before timeout
// - Open-drain reset node shared with processor
// - Each reset pulse lasts at least 140 ms
// - Manual reset low clears watchdog counter
// - Low output low, high output high in reset
module watchdog_reset_supervisor
    import wdog_pkg::*;
#(
    parameter logic [CNT_W-1:0] WINDOW_LEN = CNT_W'(WINDOW_CYCLES),
    parameter logic [CNT_W-1:0] HOLD_LEN   = CNT_W'(RESET_HOLD_CYCLES)
)(
    input  wire logic           clk_sys,
    input  wire logic           nrst,
    input  wire logic           clk_en,
    input  wire logic           watchdog_kick_input,
    input  wire logic           manual_reset_n,
    input  wire logic           reset_node_in,
    output reset_pins_type      reset_pins,
    output kick_drive_type      kick_drive
);

    typedef enum logic [0:0] {ST_RUN, ST_RESET} mode_type;

    typedef struct packed {
        mode_type         mode;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] hold_cnt;
        reset_pins_type   pins;
        kick_drive_type   drive;
    } sup_state_type;

    localparam logic [CNT_W-1:0] SELF_HIGH_AT =
        CNT_W'((64'(WINDOW_LEN) * SELF_DRIVE_HIGH) / SELF_DRIVE_DEN);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    sup_state_type state_r;
    sup_state_type state_nxt;
    logic          kick_edge;
    logic          force_reset;

    // Fast sampling at 8 ns catches a 50 ns pulse on both edges
    kick_edge_detect u_kick (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .clk_en    (clk_en),
        .kick_in   (watchdog_kick_input),
        .kick_edge (kick_edge)
    );

    // Manual reset or processor pulling the shared node
    assign force_reset = !manual_reset_n | (state_r.mode == ST_RUN & !reset_node_in);

    function automatic reset_pins_type pins_for(input logic asserted);
        reset_pins_type p;
        p.reset_n      = !asserted;
        p.reset_hi     = asserted;
        p.reset_od_out = 1'b0;
        p.reset_od_oe  = !asserted; // Low enable pulls the node low
        return p;
    endfunction

    // Window counting and reset sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r.mode)
            ST_RUN: begin
                if (force_reset || state_r.win_cnt >= WINDOW_LEN - ONE) begin
                    state_nxt.mode     = ST_RESET;
                    state_nxt.win_cnt  = '0;
                    state_nxt.hold_cnt = '0;
                end else if (kick_edge) begin
                    state_nxt.win_cnt = '0;
                end else begin
                    state_nxt.win_cnt = state_r.win_cnt + ONE;
                end
            end
            ST_RESET: begin
                state_nxt.win_cnt = '0;
                if (!manual_reset_n) begin
                    state_nxt.hold_cnt = '0; // Hold restarts after release
                end else if (state_r.hold_cnt >= HOLD_LEN - ONE) begin
                    state_nxt.mode = ST_RUN;
                end else begin
                    state_nxt.hold_cnt = state_r.hold_cnt + ONE;
                end
            end
        endcase
        state_nxt.pins = pins_for(state_nxt.mode == ST_RESET);
        // Weak driver follows the window; only wins when pin floats
        state_nxt.drive.kick_drive_oe  = 1'b0;
        state_nxt.drive.kick_drive_out = (state_nxt.win_cnt >= SELF_HIGH_AT);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r.mode     <= ST_RESET;
            state_r.win_cnt  <= '0;
            state_r.hold_cnt <= '0;
            state_r.pins     <= '{reset_n: 1'b0, reset_hi: 1'b1, reset_od_out: 1'b0, reset_od_oe: 1'b0};
            state_r.drive    <= '{kick_drive_out: 1'b0, kick_drive_oe: 1'b0};
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign reset_pins = state_r.pins;
    assign kick_drive = state_r.drive;

    // Checks, built on a few named steps of the reset sequence
    sequence s_in_reset;
        state_r.mode == ST_RESET;
    endsequence

    // Last counted cycle of a silent window
    sequence s_expiry;
        clk_en && state_r.mode == ST_RUN && state_r.win_cnt == WINDOW_LEN - ONE;
    endsequence

    // Hold ends and the block returns to counting
    sequence s_release;
        (clk_en && state_r.mode == ST_RESET) ##1 (state_r.mode == ST_RUN);
    endsequence

    a_hold_counter_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_in_reset |-> state_r.win_cnt == '0)
        else $error("watchdog counter moved during reset");

    a_outputs_agree: assert property (@(posedge clk_sys) disable iff (!nrst)
        reset_pins.reset_n == !reset_pins.reset_hi)
        else $error("reset outputs disagree");

    a_od_matches_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        reset_pins.reset_od_oe == reset_pins.reset_n)
        else $error("open-drain leg not following reset");

    a_timeout_fires: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && state_r.mode == ST_RUN && state_r.win_cnt == WINDOW_LEN - ONE)
        |=> state_r.mode == ST_RESET)
        else $error("window expiry did not raise reset");

    a_kick_restarts: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && kick_edge && !force_reset && state_r.mode == ST_RUN && state_r.win_cnt < WINDOW_LEN - ONE)
        |=> state_r.win_cnt == '0)
        else $error("kick edge did not restart window");

    a_release_counts: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_release |-> state_r.win_cnt == '0)
        else $error("window not fresh at release");

    // Outputs go inactive together at release
    a_release_pins: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_release |-> reset_pins.reset_n && reset_pins.reset_od_oe && !reset_pins.reset_hi)
        else $error("outputs not released with hold");

    // Expiry drives every output to its asserted level
    a_expiry_pins: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_expiry |=> !reset_pins.reset_n && reset_pins.reset_hi && !reset_pins.reset_od_oe)
        else $error("expiry did not assert outputs");

    // Low output and open-drain leg stay asserted for the whole hold
    a_pins_in_reset: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_in_reset |-> !reset_pins.reset_n && !reset_pins.reset_od_oe)
        else $error("outputs inactive during hold");

    // Counter never passes the window length while running
    a_counter_bounded: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_r.mode == ST_RUN |-> state_r.win_cnt < WINDOW_LEN)
        else $error("window counter overran");

    // Processor pulling the shared node starts a reset
    a_node_forces: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && state_r.mode == ST_RUN && !reset_node_in) |=> state_r.mode == ST_RESET)
        else $error("shared node low ignored");

    // Hold counter advances one step per enabled cycle
    a_hold_counts_up: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && manual_reset_n && state_r.mode == ST_RESET && state_r.hold_cnt < HOLD_LEN - ONE)
        |=> state_r.hold_cnt == $past(state_r.hold_cnt) + ONE)
        else $error("hold counter skipped");

    // Manual reset keeps the hold count at its start
    a_manual_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && state_r.mode == ST_RESET && !manual_reset_n) |=> state_r.hold_cnt == '0)
        else $error("hold counted while manual low");

    // Enable low freezes everything, counters included
    a_freeze_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
        !clk_en |=> $stable(state_r))
        else $error("state moved with enable low");

    // Weak drive low for the first seven eighths
    a_self_drive_low: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_r.win_cnt < SELF_HIGH_AT) |-> !kick_drive.kick_drive_out)
        else $error("self drive high too early");

    a_hold_min_len: assert property (@(posedge clk_sys) disable iff (!nrst)
        ($rose(state_r.mode == ST_RESET) && state_r.hold_cnt == '0)
        |-> state_r.mode == ST_RESET [*8])
        else $error("reset pulse too short");

    a_release_at_count: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_r.mode == ST_RESET && state_r.hold_cnt < HOLD_LEN - ONE) |=> state_r.mode == ST_RESET)
        else $error("reset released before hold count");

    a_manual_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
        (clk_en && !manual_reset_n) |=> state_r.mode == ST_RESET && state_r.win_cnt == '0)
        else $error("manual reset did not clear watchdog");

    a_self_drive_high: assert property (@(posedge clk_sys) disable iff (!nrst)
        (state_r.win_cnt >= SELF_HIGH_AT) |-> kick_drive.kick_drive_out)
        else $error("self drive low in last eighth");

endmodule

// ===== design/wdog_pkg.sv
package wdog_pkg;

    // Clock rate and documented times
    localparam int unsigned CLK_PERIOD_PS      = 8000;
    localparam longint      WINDOW_MS          = 1600;   // Nominal watchdog window
    localparam longint      RESET_HOLD_MS      = 140;    // Least reset pulse length
    localparam longint      KICK_PULSE_NS      = 50;     // Shortest kick pulse seen
    localparam longint      PS_PER_MS          = 64'd1000000000;
    localparam longint      PS_PER_NS          = 64'd1000;

    // Window rounds down, hold rounds up
    localparam longint      WINDOW_CYCLES      = (WINDOW_MS * PS_PER_MS) / CLK_PERIOD_PS;
    localparam longint      RESET_HOLD_CYCLES  = (RESET_HOLD_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint      KICK_PULSE_CYCLES  = (KICK_PULSE_NS * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Self-service driver goes high for the last eighth of the window
    localparam int unsigned SELF_DRIVE_DEN     = 8;
    localparam int unsigned SELF_DRIVE_HIGH    = 7;

    localparam int unsigned CNT_W              = 32;

    // Reset output pins, open-drain leg uses oe low while driving
    typedef struct packed {
        logic reset_n;
        logic reset_hi;
        logic reset_od_out;
        logic reset_od_oe;
    } reset_pins_type;

    // Weak self-service driver for the kick pin
    typedef struct packed {
        logic kick_drive_out;
        logic kick_drive_oe;
    } kick_drive_type;

endpackage

// ===== tb/kick_host.sv
`timescale 1ns/1ns
module kick_host
    import wdog_pkg::*;
(
    input  wire logic           host_en,
    input  wire logic           host_lvl,
    input  wire kick_drive_type kick_drive,
    output logic                kick_pin
);
    // Host drive is strong and overrides the weak self-service drive
    always_comb begin
        if (host_en) begin
            kick_pin = host_lvl;
        end else if (!kick_drive.kick_drive_oe) begin
            kick_pin = kick_drive.kick_drive_out;
        end else begin
            kick_pin = ~kick_drive.kick_drive_out; // Undriven pin shows the inverse of the weak drive level
        end
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb;
    import wdog_pkg::*;
    localparam int  WL = 64;
    localparam int  HL = 16;
    logic           clk_sys = 0, nrst = 0, manual_reset_n = 1, proc_rst_n = 1, host_en = 1, host_lvl = 0;
    logic           kick_pin, node, clk_en = 1;
    reset_pins_type reset_pins;
    kick_drive_type kick_drive;
    int             num_errors = 0, tests_run = 0, cyc = 0, n, hi;
    always #4 clk_sys = ~clk_sys;
    // Pulled-up node, either party may pull it low
    assign node = proc_rst_n & (reset_pins.reset_od_oe | reset_pins.reset_od_out);
    watchdog_reset_supervisor #(.WINDOW_LEN(32'(WL)), .HOLD_LEN(32'(HL))) u_watchdog_reset_supervisor (
        .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .watchdog_kick_input(kick_pin),
        .manual_reset_n(manual_reset_n), .reset_node_in(node), .reset_pins(reset_pins), .kick_drive(kick_drive));
    kick_host u_kick_host (.host_en(host_en), .host_lvl(host_lvl), .kick_drive(kick_drive), .kick_pin(kick_pin));
    task automatic results;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard, whole run needs about a thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            num_errors++;
            results();
        end
    end
    task automatic check_bit(string what, logic exp, logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_range(string what, int lo, int hi_b, int got);
        tests_run++;
        if (got < lo || got > hi_b) begin
            num_errors++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi_b, got);
        end
    endtask
    // Cycles while reset stays asserted, or until it asserts
    task automatic hold_len(output int k);
        k = 0;
        while (reset_pins.reset_n === 1'b0 && k < 500) begin
            @(posedge clk_sys);
            k++;
        end
    endtask
    task automatic run_len(output int k);
        k = 0;
        while (reset_pins.reset_n !== 1'b0 && k < 500) begin
            @(posedge clk_sys);
            k++;
        end
    endtask
    task automatic t_reset;
        check_bit("reset_n in nrst", 1'b0, reset_pins.reset_n);
        check_bit("reset_hi in nrst", 1'b1, reset_pins.reset_hi);
        check_bit("od_oe in nrst", 1'b0, reset_pins.reset_od_oe);
        nrst <= 1'b1;
        @(posedge clk_sys);
        hold_len(n);
        check_range("hold after nrst", HL, HL + 3, n);
        check_bit("reset_hi released", 1'b0, reset_pins.reset_hi);
        check_bit("od_oe released", 1'b1, reset_pins.reset_od_oe);
    endtask
    // Steady kick pin: window expires twice, counter restarts from each reset release
    task automatic t_timeout;
        run_len(n);
        check_range("first window", WL - 2, WL + 2, n);
        hold_len(n);
        check_range("timeout hold", HL, HL + 3, n);
        run_len(n);
        check_range("second window", WL - 2, WL + 2, n);
        hold_len(n);
    endtask
    // Seven-cycle high pulses every half window keep reset away
    task automatic t_kick;
        repeat (6) begin
            repeat (WL / 2 - 7) @(posedge clk_sys);
            host_lvl <= 1'b1;
            repeat (7) @(posedge clk_sys);
            host_lvl <= 1'b0;
            check_bit("reset_n while kicked", 1'b1, reset_pins.reset_n);
        end
        run_len(n);
        check_range("window after last edge", WL - 1, WL + 6, n);
        hold_len(n);
    endtask
    // Floating pin: weak drive serves itself, never times out
    task automatic t_float;
        host_en <= 1'b0;
        hi = 0;
        repeat (4 * WL) begin
            @(posedge clk_sys);
            if (kick_drive.kick_drive_out === 1'b1) hi++;
            if (reset_pins.reset_n !== 1'b1) n = -1;
        end
        check_range("self drive high share", 1, WL / 2, hi);
        check_range("no timeout floating", 0, 500, n);
        host_en <= 1'b1;
    endtask
    task automatic t_manual;
        manual_reset_n <= 1'b0;
        repeat (30) @(posedge clk_sys);
        check_bit("reset_n manual", 1'b0, reset_pins.reset_n);
        manual_reset_n <= 1'b1;
        @(posedge clk_sys);
        hold_len(n);
        check_range("hold after manual", HL, HL + 4, n);
    endtask
    task automatic t_node;
        proc_rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        proc_rst_n <= 1'b1;
        @(posedge clk_sys);
        check_bit("reset_hi node pulled", 1'b1, reset_pins.reset_hi);
        hold_len(n);
        check_range("hold after node", HL - 2, HL + 4, n);
    endtask
    // Enable low for 40 cycles stretches the window by as much
    task automatic t_freeze;
        clk_en <= 1'b0;
        repeat (40) @(posedge clk_sys);
        check_bit("reset_n frozen", 1'b1, reset_pins.reset_n);
        clk_en <= 1'b1;
        run_len(n);
        check_range("window with freeze", WL + 34, WL + 42, n + 40);
        hold_len(n);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        t_reset();
        t_timeout();
        t_kick();
        t_float();
        t_manual();
        t_node();
        t_freeze();
        results();
    end
endmodule
